//--- bbs_pkg.sv
// Contract
// RULE_01: Direction bit 0 makes strobe input, 1 output; register or pin by mode.
// RULE_02: Block start marks channel status block start, frame zero of stream.
// RULE_03: Input strobe sampled rising frame clock, falling when invert set.
// RULE_04: High sampled strobe means block start; source drives it high then.
// RULE_05: Output strobe rises every 192nd falling edge stereo, 384th mono.
// RULE_06: Output strobe returns low on next active edge, one frame wide.
// RULE_07: With invert set the output strobe changes on rising edges.
// RULE_08: Hardware mode: justified formats non-inverted, I2S format inverted.
// RULE_09: Software mode takes channel status only from the software buffer.
// RULE_10: Hardware pin method derives status bits from four flag pins.
// RULE_11: Copy/generation 00,01,10 consumer copied; 11 professional, no copy.
// RULE_12: Non-PCM pin 0 linear PCM, 1 non-audio data.
// RULE_13: Pre-filter pin 0 marks 50/15us emphasis, 1 marks none.
// RULE_14: Serial method clocks status input on both frame clock edges.
// RULE_15: Serial method lets every status bit come from serial input.
// RULE_16: User bits taken serially in both modes into user slots.
// RULE_17: Validity from register in software mode, serial pin in hardware.
// RULE_18: Validity 0 means valid sample, 1 means defective.
// RULE_19: Formats map to alignment, delay, edge and frame phase settings.
// RULE_20: Frame clock toggles at sample rate, one stereo pair per period.
// RULE_21: Frame clock latches status, user, validity in hardware; user in software.
// RULE_22: Frame counter restarts at zero after reset and accepted block start.
package bbs_pkg;
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_CS_SW     = 4'h8;
  localparam logic [3:0] REG_CS_EFF    = 4'hc;
  localparam int CTRL_DIR_POS   = 0;
  localparam int CTRL_VAL_POS   = 1;
  localparam int CTRL_MONO_POS  = 2;
  localparam int CTRL_INV_POS   = 3;
  localparam int CTRL_ALIGN_POS = 4;
  localparam int CTRL_EDGE_POS  = 5;
  localparam int CTRL_DELAY_POS = 6;
  localparam int CTRL_WIDTH     = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [31:0] CS_SW_RESET = 32'h0000_0000;
  localparam int CS_PRO_POS    = 0;
  localparam int CS_NONPCM_POS = 1;
  localparam int CS_COPY_POS   = 2;
  localparam int CS_PRE_FILTER_FLAG_INPUT_POS   = 3;
  localparam int CS_GEN_POS    = 15;
  localparam logic [2:0] PRE_FILTER_FLAG_INPUT_5015 = 3'h1;
  localparam logic [2:0] PRE_FILTER_FLAG_INPUT_NONE = 3'h0;
  localparam logic [8:0] LAST_STEREO = 9'h0bf;
  localparam logic [8:0] LAST_MONO   = 9'h17f;
  localparam logic [1:0] FMT_LEFT  = 2'h0;
  localparam logic [1:0] FMT_I2S   = 2'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [8:0] frame_index;
    logic       block_start;
    logic       cs_a;
    logic       cs_b;
    logic       user_a;
    logic       user_b;
    logic       valid_a;
    logic       valid_b;
  } bbs_frame_t;

  typedef struct packed {
    logic       align_right;
    logic       bit_delay;
    logic       edge_falling;
    logic       phase_inverted;
  } bbs_format_t;
endpackage

//--- bbs_side_data.sv
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module bbs_side_data (
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [3:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               hw_mode_in,
  input  wire logic               direction_pin,
  input  wire logic [1:0]         format_pins,
  input  wire logic               status_input_method,
  input  wire logic               duplication_flag_input,
  input  wire logic               generation_bit_in,
  input  wire logic               nonpcm_flag_input,
  input  wire logic               pre_filter_flag_input,
  input  wire logic               status_serial_in,
  input  wire logic               side_info_in,
  input  wire logic               sample_defect_in,
  input  wire logic               frame_clock,
  input  wire logic               block_begin_strobe_i,
  output logic                    block_begin_strobe_o,
  output logic                    block_begin_strobe_oe,
  output bbs_pkg::bbs_frame_t     frame_out,
  output logic                    frame_out_valid,
  output bbs_pkg::bbs_format_t    format_out
);

  // Pin synchronisers; stage one feeds stage two only
  localparam int NPIN = 14;
  logic [NPIN-1:0] pin_meta_reg;
  logic [NPIN-1:0] pin_sync_reg;
  logic            fclk_prev_reg;
  logic [NPIN-1:0] pin_raw;
  assign pin_raw = {hw_mode_in, direction_pin, format_pins,
                    status_input_method, duplication_flag_input,
                    generation_bit_in, nonpcm_flag_input,
                    pre_filter_flag_input, status_serial_in, side_info_in,
                    sample_defect_in, frame_clock, block_begin_strobe_i};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic       hw_s;
  logic       dir_pin_s;
  logic [1:0] fmt_s;
  logic       method_s;
  logic       dup_s;
  logic       gen_s;
  logic       nonpcm_s;
  logic       pre_filter_flag_input_s;
  logic       cs_ser_s;
  logic       user_s;
  logic       defect_s;
  logic       fclk_s;
  logic       strobe_in_s;
  assign hw_s        = pin_sync_reg[13];
  assign dir_pin_s   = pin_sync_reg[12];
  assign fmt_s       = pin_sync_reg[11:10];
  assign method_s    = pin_sync_reg[9];
  assign dup_s       = pin_sync_reg[8];
  assign gen_s       = pin_sync_reg[7];
  assign nonpcm_s    = pin_sync_reg[6];
  assign pre_filter_flag_input_s      = pin_sync_reg[5];
  assign cs_ser_s    = pin_sync_reg[4];
  assign user_s      = pin_sync_reg[3];
  assign defect_s    = pin_sync_reg[2];
  assign fclk_s      = pin_sync_reg[1];
  assign strobe_in_s = pin_sync_reg[0];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fclk_prev_reg <= 1'b0;
    end else begin
      fclk_prev_reg <= fclk_s;
    end
  end

  // Software registers
  logic [6:0]  ctrl_reg;
  logic [31:0] cs_sw_reg;

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Effective settings by mode
  logic dir_eff;
  logic inv_eff;
  logic mono_eff;
  logic fclk_rise;
  logic fclk_fall;
  logic out_edge;
  logic in_edge;
  logic frame_edge;
  assign dir_eff   = hw_s ? dir_pin_s : ctrl_reg[bbs_pkg::CTRL_DIR_POS]; // RULE_01
  assign inv_eff   = hw_s ? (fmt_s == bbs_pkg::FMT_I2S)
                          : ctrl_reg[bbs_pkg::CTRL_INV_POS]; // RULE_08
  assign mono_eff  = hw_s ? 1'b0 : ctrl_reg[bbs_pkg::CTRL_MONO_POS];
  assign fclk_rise = fclk_s && !fclk_prev_reg;
  assign fclk_fall = !fclk_s && fclk_prev_reg;
  assign out_edge  = inv_eff ? fclk_rise : fclk_fall; // RULE_05 RULE_07
  assign in_edge   = inv_eff ? fclk_fall : fclk_rise; // RULE_03
  assign frame_edge = dir_eff ? out_edge : in_edge; // RULE_20

  // Format mapping for the serial port
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      format_out <= '0;
    end else if (hw_s) begin // RULE_19
      format_out.align_right    <= fmt_s[1];
      format_out.bit_delay      <= (fmt_s == bbs_pkg::FMT_I2S);
      format_out.edge_falling   <= 1'b0;
      format_out.phase_inverted <= (fmt_s == bbs_pkg::FMT_I2S);
    end else begin
      format_out.align_right    <= ctrl_reg[bbs_pkg::CTRL_ALIGN_POS];
      format_out.bit_delay      <= ctrl_reg[bbs_pkg::CTRL_DELAY_POS];
      format_out.edge_falling   <= ctrl_reg[bbs_pkg::CTRL_EDGE_POS];
      format_out.phase_inverted <= ctrl_reg[bbs_pkg::CTRL_INV_POS];
    end
  end

  // Block frame counter
  logic [8:0] cnt_reg;
  logic [8:0] cnt_last;
  logic       in_start;
  logic       strobe_out_reg;
  assign cnt_last = mono_eff ? bbs_pkg::LAST_MONO : bbs_pkg::LAST_STEREO;
  assign in_start = !dir_eff && in_edge && strobe_in_s; // RULE_04

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0; // RULE_22
    end else if (in_start) begin
      cnt_reg <= '0; // RULE_22
    end else if (frame_edge) begin
      cnt_reg <= (cnt_reg >= cnt_last) ? 9'h000 : cnt_reg + 9'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strobe_out_reg <= 1'b0;
    end else if (!dir_eff) begin
      strobe_out_reg <= 1'b0;
    end else if (out_edge) begin
      strobe_out_reg <= (cnt_reg >= cnt_last); // RULE_05 RULE_06
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      block_begin_strobe_oe <= 1'b0;
    end else begin
      block_begin_strobe_oe <= dir_eff; // RULE_01
    end
  end
  assign block_begin_strobe_o = strobe_out_reg;

  // Serial side data, both frame clock edges
  logic cs_a_reg;
  logic cs_b_reg;
  logic user_a_reg;
  logic user_b_reg;
  logic val_a_reg;
  logic val_b_reg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cs_a_reg   <= 1'b0;
      cs_b_reg   <= 1'b0;
      user_a_reg <= 1'b0;
      user_b_reg <= 1'b0;
      val_a_reg  <= 1'b0;
      val_b_reg  <= 1'b0;
    end else if (fclk_rise) begin // RULE_14 RULE_16 RULE_21
      cs_a_reg   <= cs_ser_s;
      user_a_reg <= user_s;
      val_a_reg  <= defect_s;
    end else if (fclk_fall) begin
      cs_b_reg   <= cs_ser_s;
      user_b_reg <= user_s;
      val_b_reg  <= defect_s;
    end
  end

  // Channel status word from dedicated pins
  logic [31:0] cs_pin_word;
  always_comb begin
    cs_pin_word = '0;
    if (dup_s && gen_s) begin
      cs_pin_word[bbs_pkg::CS_PRO_POS] = 1'b1; // RULE_11
    end else begin
      cs_pin_word[bbs_pkg::CS_COPY_POS] = dup_s; // RULE_11
      cs_pin_word[bbs_pkg::CS_GEN_POS]  = gen_s;
    end
    cs_pin_word[bbs_pkg::CS_NONPCM_POS] = nonpcm_s; // RULE_12
    cs_pin_word[bbs_pkg::CS_PRE_FILTER_FLAG_INPUT_POS +: 3] =
      pre_filter_flag_input_s ? bbs_pkg::PRE_FILTER_FLAG_INPUT_NONE : bbs_pkg::PRE_FILTER_FLAG_INPUT_5015; // RULE_13
  end

  // Word-based sources cover the first 32 bits; later block bits send zero
  logic [31:0] cs_word;
  logic        serial_cs;
  logic        cs_word_bit;
  assign serial_cs = hw_s && method_s; // RULE_15
  assign cs_word   = hw_s ? cs_pin_word : cs_sw_reg; // RULE_09 RULE_10
  assign cs_word_bit = (cnt_reg < 9'h020) ? cs_word[cnt_reg[4:0]] : 1'b0;

  logic val_sw;
  assign val_sw = ctrl_reg[bbs_pkg::CTRL_VAL_POS]; // RULE_18

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      frame_out       <= '0;
      frame_out_valid <= 1'b0;
    end else begin
      frame_out_valid <= frame_edge && !in_start;
      if (in_start || frame_edge) begin
        frame_out.frame_index <= in_start ? 9'h000 : cnt_reg;
        frame_out.block_start <= in_start || (cnt_reg == 9'h000); // RULE_02
        frame_out.cs_a    <= serial_cs ? cs_a_reg : cs_word_bit;
        frame_out.cs_b    <= serial_cs ? cs_b_reg : cs_word_bit;
        frame_out.user_a  <= user_a_reg; // RULE_16
        frame_out.user_b  <= user_b_reg;
        frame_out.valid_a <= hw_s ? val_a_reg : val_sw; // RULE_17
        frame_out.valid_b <= hw_s ? val_b_reg : val_sw;
      end
    end
  end

  // AXI4-Lite slave; address and data taken in either order
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [3:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        do_write;
  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_got_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_got_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      w_got_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_got_reg <= 1'b0;
    end
  end

  logic [31:0] ctrl_next;
  assign ctrl_next = merge_strb({25'h000_0000, ctrl_reg}, wdata_reg,
                                wstrb_reg);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg  <= bbs_pkg::CTRL_RESET;
      cs_sw_reg <= bbs_pkg::CS_SW_RESET;
    end else if (do_write) begin
      if (awaddr_reg == bbs_pkg::REG_CTRL) begin
        ctrl_reg <= ctrl_next[bbs_pkg::CTRL_WIDTH-1:0];
      end
      if (awaddr_reg == bbs_pkg::REG_CS_SW) begin
        cs_sw_reg <= merge_strb(cs_sw_reg, wdata_reg, wstrb_reg); // RULE_09
      end
    end
  end

  // Status and effective word registers are read-only; writes there answer SLVERR
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bbs_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_reg == bbs_pkg::REG_CTRL ||
                       awaddr_reg == bbs_pkg::REG_CS_SW)
                      ? bbs_pkg::RESP_OKAY : bbs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic [31:0] status_word;
  assign status_word = {18'h0_0000, hw_s, serial_cs, mono_eff, inv_eff,
                        dir_eff, cnt_reg};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= bbs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= bbs_pkg::RESP_OKAY;
      case (s_axi_araddr)
        bbs_pkg::REG_CTRL:   s_axi_rdata <= {25'h000_0000, ctrl_reg};
        bbs_pkg::REG_STATUS: s_axi_rdata <= status_word;
        bbs_pkg::REG_CS_SW:  s_axi_rdata <= cs_sw_reg;
        bbs_pkg::REG_CS_EFF: s_axi_rdata <= cs_word;
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= bbs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  strobe_rise_a: assert property ($rose(strobe_out_reg) |-> // RULE_05
      cnt_reg == 9'h000 && $past(cnt_reg) >= $past(cnt_last))
    else $error("strobe rose away from block wrap");
  strobe_width_a: assert property (strobe_out_reg && out_edge && dir_eff // RULE_06
      |=> !strobe_out_reg)
    else $error("strobe wider than one frame");
  dir_oe_a: assert property (hw_s && $stable(dir_pin_s) // RULE_01
      |=> block_begin_strobe_oe == $past(dir_pin_s))
    else $error("strobe direction not from pin");
  in_restart_a: assert property (in_start |=> cnt_reg == 9'h000 // RULE_22
      && frame_out.block_start && frame_out.frame_index == 9'h000)
    else $error("input block start not accepted");
  i2s_phase_a: assert property (hw_s && fmt_s == bbs_pkg::FMT_I2S // RULE_08
      |-> in_edge == fclk_fall && out_edge == fclk_rise)
    else $error("I2S edge choice wrong");
  pro_flag_a: assert property (hw_s && dup_s && gen_s // RULE_11
      |-> cs_word[bbs_pkg::CS_PRO_POS] && !cs_word[bbs_pkg::CS_COPY_POS])
    else $error("professional code not encoded");
  pre_filter_flag_input_map_a: assert property (hw_s && !pre_filter_flag_input_s // RULE_13
      |-> cs_word[bbs_pkg::CS_PRE_FILTER_FLAG_INPUT_POS +: 3] == bbs_pkg::PRE_FILTER_FLAG_INPUT_5015)
    else $error("emphasis not marked");
  val_sw_a: assert property (!hw_s && frame_edge && $stable(ctrl_reg) // RULE_17
      |=> frame_out.valid_a == $past(val_sw))
    else $error("software validity not sent");
  frame_zero_a: assert property (frame_out_valid // RULE_02
      |-> frame_out.block_start == (frame_out.frame_index == 9'h000))
    else $error("block start not at frame zero");
  serial_cs_a: assert property (serial_cs && fclk_rise // RULE_14
      |=> cs_a_reg == $past(cs_ser_s))
    else $error("serial status bit missed");
  bresp_a: assert property (do_write |=> s_axi_bvalid)
    else $error("write not answered");

  out_block_c: cover property (dir_eff && $rose(strobe_out_reg));
  in_block_c: cover property (in_start);
  mono_block_c: cover property (mono_eff && $rose(strobe_out_reg));
  serial_mode_c: cover property (serial_cs && frame_out_valid);

endmodule
`default_nettype wire

//--- bbs_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module bbs_src_model (
  output logic            frame_clock,
  output logic            strobe,
  output logic            cs_bit,
  output logic            user_bit,
  output logic            val_bit,
  input  wire logic       go,
  input  wire logic       on_fall,
  input  wire logic [5:0] bits
);
  initial frame_clock = 1'b0;
  initial strobe = 1'b0;
  initial {cs_bit, user_bit, val_bit} = 3'h0;
  // Runs free, one sample pair per period
  always #24 frame_clock = ~frame_clock;
  // A bits settle before the rising edge, B bits before the falling one
  // Change lands on a falling ref_clk edge, clear of the sampling edge
  always @(negedge frame_clock) begin
    #4 {cs_bit, user_bit, val_bit} = bits[5:3];
  end
  always @(posedge frame_clock) begin
    #4 {cs_bit, user_bit, val_bit} = bits[2:0];
  end
  // Half-frame pulse, so only the wanted sampling edge sees it high
  always @(posedge go) begin
    if (on_fall) @(posedge frame_clock);
    else @(negedge frame_clock);
    #12 strobe = 1'b1;
    #24 strobe = 1'b0;
  end
endmodule
`default_nettype wire

//--- bbs_side_data_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module bbs_side_data_bench;
  logic                 ref_clk = 1'b0;
  logic                 nrst = 1'b0;
  logic [3:0]           awaddr = 4'h0;
  logic [3:0]           araddr = 4'h0;
  logic [31:0]          wdata = 32'h0000_0000;
  logic                 awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                 arvalid = 1'b0, rready = 1'b0;
  logic                 hw = 1'b0, dirp = 1'b0, csm = 1'b0, dup = 1'b0;
  logic                 gen = 1'b0, npcm = 1'b0, pf = 1'b0;
  logic                 go = 1'b0, on_fall = 1'b0;
  logic [1:0]           fmt = 2'h0;
  logic [5:0]           bits = 6'h00;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic                 so, soe, fov, fc, src_s, cs_s, u_s, v_s;
  logic [1:0]           bresp, rresp, rs;
  logic [31:0]          rdata, rd;
  bbs_pkg::bbs_frame_t  fo;
  bbs_pkg::bbs_format_t fmo;
  wire logic            line;
  int                   failures = 0;
  int                   checks = 0;
  int                   cycles = 0;
  assign line = soe ? so : src_s;

  bbs_side_data u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hw_mode_in(hw), .direction_pin(dirp),
    .format_pins(fmt), .status_input_method(csm),
    .duplication_flag_input(dup), .generation_bit_in(gen),
    .nonpcm_flag_input(npcm), .pre_filter_flag_input(pf),
    .status_serial_in(cs_s), .side_info_in(u_s),
    .sample_defect_in(v_s), .frame_clock(fc),
    .block_begin_strobe_i(line), .block_begin_strobe_o(so),
    .block_begin_strobe_oe(soe), .frame_out(fo),
    .frame_out_valid(fov), .format_out(fmo)
  );
  bbs_src_model u_src (
    .frame_clock(fc), .strobe(src_s), .cs_bit(cs_s), .user_bit(u_s),
    .val_bit(v_s), .go(go), .on_fall(on_fall), .bits(bits)
  );

  always #2 ref_clk = ~ref_clk;
  // Longest path is two mono blocks, well under this ceiling
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Ready is looked at mid-cycle, so it holds through the taking edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge ref_clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge ref_clk);
      ta = awvalid && awready; tw = wvalid && wready;
      tb = bvalid; rs = bresp;
      @(posedge ref_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    `CHK(rs, er)
  endtask

  task automatic rd_reg(input logic [3:0] a);
    logic ta, tr;
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge ref_clk);
      ta = arvalid && arready; tr = rvalid; rd = rdata; rs = rresp;
      @(posedge ref_clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask

  task automatic frames(input int n);
    int k;
    k = 0;
    while (k < n) begin
      @(posedge ref_clk);
      if (fov === 1'b1) k++;
    end
  endtask

  // Counts from the first pulse to the second: a mode change may leave a short block
  task automatic period(input logic fall, input int en, input logic lvl);
    logic pv, ps;
    int n, w, k;
    pv = fc; ps = so; n = 0; w = 0; k = 0;
    while (k < 2) begin
      @(posedge ref_clk);
      if (fall ? (pv && !fc) : (!pv && fc)) n++;
      if (k == 1 && ps && !so) w = n;
      if (!ps && so) begin
        k++;
        if (k == 1) n = 0;
      end
      pv = fc; ps = so;
    end
    `CHK(n, en)
    `CHK(w, 1)
    `CHK(fc, lvl)
    `CHK(soe, 1'b1)
  endtask

  task automatic t_regs;
    rd_reg(bbs_pkg::REG_CTRL);
    `CHK(rd, 32'h0000_0000)
    `CHK(soe, 1'b0)
    rd_reg(bbs_pkg::REG_CS_SW);
    `CHK(rd, 32'h0000_0000)
    wr(bbs_pkg::REG_STATUS, 32'h0000_0001, bbs_pkg::RESP_SLVERR);
    wr(bbs_pkg::REG_CS_SW, 32'h1234_5678, bbs_pkg::RESP_OKAY);
    rd_reg(bbs_pkg::REG_CS_EFF);
    `CHK(rd, 32'h1234_5678)
  endtask

  task automatic t_out_sw;
    wr(bbs_pkg::REG_CTRL, 32'h0000_0001, bbs_pkg::RESP_OKAY);
    period(1'b1, 192, 1'b0);
    wr(bbs_pkg::REG_CTRL, 32'h0000_0005, bbs_pkg::RESP_OKAY);
    period(1'b1, 384, 1'b0);
    wr(bbs_pkg::REG_CTRL, 32'h0000_0009, bbs_pkg::RESP_OKAY);
    period(1'b0, 192, 1'b1);
  endtask

  task automatic t_in(input logic inv);
    wr(bbs_pkg::REG_CTRL, {28'h000_0000, inv, 3'h0}, bbs_pkg::RESP_OKAY);
    @(posedge ref_clk);
    on_fall <= inv; go <= 1'b1;
    while (src_s !== 1'b1) @(posedge ref_clk);
    while (src_s !== 1'b0) @(posedge ref_clk);
    go <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(fo.frame_index, 9'h000)
    `CHK(fo.block_start, 1'b1)
    frames(1);
    `CHK(fo.frame_index, 9'h000)
    `CHK(fo.block_start, 1'b1)
    frames(1);
    `CHK(fo.frame_index, 9'h001)
  endtask

  task automatic t_valid_sw;
    bits <= 6'h10;
    wr(bbs_pkg::REG_CTRL, 32'h0000_0002, bbs_pkg::RESP_OKAY);
    frames(3);
    `CHK({fo.valid_a, fo.valid_b}, 2'h3)
    `CHK({fo.user_a, fo.user_b}, 2'h2)
    wr(bbs_pkg::REG_CTRL, 32'h0000_0000, bbs_pkg::RESP_OKAY);
    frames(3);
    `CHK({fo.valid_a, fo.valid_b}, 2'h0)
  endtask

  task automatic t_hw_pins;
    logic [31:0] e;
    logic [3:0]  v;
    hw <= 1'b1; csm <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      v = i[3:0];
      {pf, npcm, gen, dup} <= v;
      repeat (6) @(posedge ref_clk);
      rd_reg(bbs_pkg::REG_CS_EFF);
      e = 32'h0000_0000;
      if (v[0] && v[1]) e[bbs_pkg::CS_PRO_POS] = 1'b1;
      else {e[bbs_pkg::CS_GEN_POS], e[bbs_pkg::CS_COPY_POS]} = v[1:0];
      e[bbs_pkg::CS_NONPCM_POS] = v[2];
      if (!v[3]) e[bbs_pkg::CS_PRE_FILTER_FLAG_INPUT_POS +: 3] = bbs_pkg::PRE_FILTER_FLAG_INPUT_5015;
      `CHK(rd, e)
    end
  endtask

  task automatic t_hw_serial;
    csm <= 1'b1; bits <= 6'h2a;
    frames(3);
    `CHK({fo.cs_a, fo.cs_b}, 2'h2)
    `CHK({fo.user_a, fo.user_b}, 2'h1)
    `CHK({fo.valid_a, fo.valid_b}, 2'h2)
  endtask

  task automatic t_hw_fmt;
    logic [3:0] ex [4];
    ex = '{4'h0, 4'h5, 4'h8, 4'h8};
    for (int f = 0; f < 4; f++) begin
      fmt <= f[1:0];
      repeat (6) @(posedge ref_clk);
      `CHK(fmo, ex[f])
      rd_reg(bbs_pkg::REG_STATUS);
      `CHK(rd[10], (f == 1))
    end
    fmt <= bbs_pkg::FMT_I2S; dirp <= 1'b1;
    period(1'b0, 192, 1'b1);
    fmt <= bbs_pkg::FMT_LEFT;
    period(1'b1, 192, 1'b0);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_out_sw();
    t_in(1'b0);
    t_in(1'b1);
    t_valid_sw();
    t_hw_pins();
    t_hw_serial();
    t_hw_fmt();
    end_of_test();
  end
endmodule
`default_nettype wire
